// file: verilog/trim_readback_pkg.sv
// Constants for the bias-trim and offset-code readback register block
// Overview of operation
// - The bias-trim register is addressed by register bits 0-2 = 1,0,1 and bank bits 3-4 = 1,0.
// - It holds six 2-bit trims at bits 5-16 in a fixed order, each resetting to 1.
// - Bits 17-31 of the bias-trim register are unused, read zero and steer nothing.
// - The readback word returns the register address in bits 0-2.
// - The readback word returns the bank address in bits 3-4.
// - The readback word returns the quadrature offset code in bits 16-23, resetting to 0x80.
// - The readback word returns the in-phase offset code in bits 24-31, resetting to 0x80.
// - The readback register is read-only, holds a fixed version in bits 5-6 and zero in 7-15.
// - Both offset code registers load half scale, 128, at power-up before calibration.
package trim_readback_pkg;
  localparam int unsigned WORD_BITS      = 32;
  localparam int unsigned ADDR_BITS      = 5;
  localparam int unsigned TRIM_LSB       = 5;
  localparam int unsigned TRIM_COUNT     = 6;
  localparam int unsigned TRIM_BITS      = 2;
  localparam int unsigned VERSION_LSB    = 5;
  localparam int unsigned Q_CODE_LSB     = 16;
  localparam int unsigned I_CODE_LSB     = 24;
  localparam int unsigned CODE_BITS      = 8;
  localparam int unsigned RB_ADDR_LSB    = 27;
  localparam logic [4:0]  BIAS_TRIM_ADDR = 5'h0D;
  localparam logic [4:0]  READBACK_CMD   = 5'h08;
  localparam logic [1:0]  TRIM_RESET     = 2'h1;
  localparam logic [7:0]  CODE_RESET     = 8'h80;
  localparam logic [1:0]  VERSION_CODE   = 2'h2; // Arbitrary value
  localparam logic [2:0]  PIN_IDLE       = 3'h4; // Strobe high, data and clock low
endpackage

// file: verilog/trim_readback_regs.sv
// Serial bias-trim register and offset-code readback register
module trim_readback_regs
  import trim_readback_pkg::*;
#(
  parameter int unsigned FRAME_BITS = WORD_BITS,  // Bits in one serial word
  parameter int unsigned TRIMS      = TRIM_COUNT, // Number of bias trims
  parameter int unsigned FIELD_BITS = TRIM_BITS   // Width of one trim field
)
(
  input  wire logic        clk,              // 10 MHz system clock
  input  wire logic        rst,              // Async reset, active high
  input  wire logic        ser_clk,          // Serial clock pin
  input  wire logic        ser_data,         // Serial data pin, bit 0 first
  input  wire logic        ser_strobe,       // Latch enable pin, high ends word
  input  wire logic [7:0]  inphase_code_in,  // Calibration in-phase code
  input  wire logic [7:0]  quad_code_in,     // Calibration quadrature code
  input  wire logic        code_load,        // Calibration code update pulse
  output logic      [1:0]  mixer_transconductance_bias, // Trim 0
  output logic      [1:0]  mixer_switch_common_mode,    // Trim 1
  output logic      [1:0]  local_osc_buffer_bias,       // Trim 2
  output logic      [1:0]  mixer_out_buffer_bias,       // Trim 3
  output logic      [1:0]  filter_bias,                 // Trim 4
  output logic      [1:0]  filter_out_buffer_bias,      // Trim 5
  output logic      [7:0]  quadrature_offset_code,      // Q offset DAC code
  output logic      [7:0]  inphase_offset_code,         // I offset DAC code
  output logic             readback_out                 // Serial readback pin
);

  // Fixed-width ports and field map cannot serve other sizes
  if (FRAME_BITS != 32) begin : g_bad_frame
    $error("Serial frame must be 32 bits");
  end
  if (TRIMS != 6) begin : g_bad_count
    $error("Exactly six trim outputs exist");
  end
  if (FIELD_BITS != 2) begin : g_bad_field
    $error("Each trim field is two bits");
  end

  // Counter needs room for one state past a full frame
  localparam int unsigned CNT_W = $clog2(FRAME_BITS + 2);
  localparam logic [CNT_W-1:0] FRAME_LAST = CNT_W'(FRAME_BITS);
  localparam logic [CNT_W-1:0] FRAME_OVER = CNT_W'(FRAME_BITS + 1);

  // Pins gathered so that one loop serves them all
  localparam int unsigned PINS = 3;
  localparam int unsigned P_CLK = 0;
  localparam int unsigned P_DAT = 1;
  localparam int unsigned P_STB = 2;
  logic [PINS-1:0] pin_raw;
  assign pin_raw = {ser_strobe, ser_data, ser_clk};

  // Three-stage synchroniser per pin; stage one may go metastable
  logic [2:0]      sync_q [PINS];
  logic [PINS-1:0] agree;
  logic            lvl_q  [PINS];
  for (genvar p = 0; p < PINS; p++) begin : g_sync
    // Reset to the idle level so no false edge follows reset
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        sync_q[p] <= {3{PIN_IDLE[p]}};
      end else begin
        sync_q[p] <= {sync_q[p][1:0], pin_raw[p]};
      end
    end

    // A change counts once stages two and three agree
    assign agree[p] = (sync_q[p][1] == sync_q[p][2]);

    // Filtered level, moved only on agreement
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        lvl_q[p] <= PIN_IDLE[p];
      end else if (agree[p]) begin
        lvl_q[p] <= sync_q[p][2];
      end
    end
  end

  // Edge strobes, one clock long each
  logic sclk_rise;
  logic sclk_fall;
  logic word_end;
  logic data_bit;
  logic strobe_lvl;
  assign sclk_rise  = agree[P_CLK] && sync_q[P_CLK][2] && !lvl_q[P_CLK];
  assign sclk_fall  = agree[P_CLK] && !sync_q[P_CLK][2] && lvl_q[P_CLK];
  assign word_end   = agree[P_STB] && sync_q[P_STB][2] && !lvl_q[P_STB];
  assign data_bit   = sync_q[P_DAT][2]; // Settled long before the clock edge
  assign strobe_lvl = lvl_q[P_STB];

  // Shift register; bit 0 arrives first so words shift in from the top
  logic [FRAME_BITS-1:0] shift_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shift_q <= '0;
    end else if (sclk_rise && !word_end) begin
      shift_q <= {data_bit, shift_q[FRAME_BITS-1:1]};
    end
  end

  // Bit counter sticks one past full, so a long frame is refused too
  logic [CNT_W-1:0] count_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_q <= '0;
    end else if (word_end) begin
      count_q <= '0;
    end else if (sclk_rise) begin
      if (count_q != FRAME_OVER) begin
        count_q <= count_q + CNT_W'(1);
      end
    end
  end

  // Only a full 32-bit transfer is acted on; short or long frames are dropped
  logic full_word;
  assign full_word = word_end && (count_q == FRAME_LAST);

  // Address decode of the finished word
  logic [ADDR_BITS-1:0] word_addr;
  logic                 trim_hit;
  logic                 rb_hit;
  assign word_addr = shift_q[ADDR_BITS-1:0];
  assign trim_hit  = full_word && (word_addr == BIAS_TRIM_ADDR);
  assign rb_hit    = full_word && (word_addr == READBACK_CMD);

  // Bias trims, one field per generate entry, all replaced together
  logic [FIELD_BITS-1:0] trim_q [TRIMS];
  for (genvar g = 0; g < TRIMS; g++) begin : g_trim
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        trim_q[g] <= TRIM_RESET;
      end else if (trim_hit) begin
        trim_q[g] <= shift_q[TRIM_LSB + g*FIELD_BITS +: FIELD_BITS];
      end
    end
  end

  // Bits 17-31 of the word are never stored, so they steer nothing
  assign mixer_transconductance_bias = trim_q[0];
  assign mixer_switch_common_mode    = trim_q[1];
  assign local_osc_buffer_bias       = trim_q[2];
  assign mixer_out_buffer_bias       = trim_q[3];
  assign filter_bias                 = trim_q[4];
  assign filter_out_buffer_bias      = trim_q[5];

  // Quadrature code starts at half scale until calibration writes it
  logic [CODE_BITS-1:0] q_code_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q_code_q <= CODE_RESET;
    end else if (code_load) begin
      q_code_q <= quad_code_in;
    end
  end

  // In-phase code, same load pulse so both codes move together
  logic [CODE_BITS-1:0] i_code_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      i_code_q <= CODE_RESET;
    end else if (code_load) begin
      i_code_q <= inphase_code_in;
    end
  end
  assign quadrature_offset_code = q_code_q;
  assign inphase_offset_code    = i_code_q;

  // Snapshot word; the echoed address rides in the request's top bits
  logic [ADDR_BITS-1:0]  rb_sel;
  logic [FRAME_BITS-1:0] rb_word;
  assign rb_sel  = shift_q[RB_ADDR_LSB +: ADDR_BITS];
  assign rb_word = {i_code_q, q_code_q, 9'h000, VERSION_CODE, rb_sel};

  // Readback request latches a snapshot; writes never change it (read-only)
  logic [FRAME_BITS-1:0] rb_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rb_q <= '0;
    end else if (rb_hit) begin
      rb_q <= rb_word;
    end else if (sclk_fall && !strobe_lvl) begin
      rb_q <= {1'b0, rb_q[FRAME_BITS-1:1]};
    end
  end

  // Bit 0 leads; each falling serial clock while strobe is low presents the next bit.
  // The snapshot wins over a shift in the same clock, so the last
  // falling edge of a request can never eat bit 0.
  assign readback_out = rb_q[0];

endmodule

// file: tb/trim_readback_checker.sv
// Port assertions for the trim and readback register block
module trim_readback_checker import trim_readback_pkg::*; (
  input wire logic clk, rst, ser_clk, ser_data, ser_strobe, code_load, readback_out,
  input wire logic [7:0] inphase_code_in, quad_code_in, quadrature_offset_code, inphase_offset_code,
  input wire logic [1:0] mixer_transconductance_bias, mixer_switch_common_mode, filter_bias,
  input wire logic [1:0] local_osc_buffer_bias, mixer_out_buffer_bias, filter_out_buffer_bias);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire [11:0] t = {filter_out_buffer_bias, filter_bias, mixer_out_buffer_bias,
    local_osc_buffer_bias, mixer_switch_common_mode, mixer_transconductance_bias};
  chk_trim_reset: assert property ($fell(rst) |-> t == 12'h555) else $error("trim reset");
  chk_code_reset: assert property ($fell(rst) |-> {inphase_offset_code,
    quadrature_offset_code} == 16'h8080 && !readback_out) else $error("code reset");
  chk_trim_hold: assert property (!ser_strobe [*6] |-> $stable(t)) else $error("trim");
  chk_trim_late: assert property ($rose(ser_strobe) |-> $stable(t) [*3]) else $error("e");
  chk_q_load: assert property (code_load |=> quadrature_offset_code == $past(quad_code_in))
    else $error("q load");
  chk_i_load: assert property (code_load |=> inphase_offset_code == $past(inphase_code_in))
    else $error("i load");
  chk_code_hold: assert property (!code_load |=> $stable({inphase_offset_code,
    quadrature_offset_code})) else $error("code moved");
  chk_rb_quiet: assert property ((ser_clk && !ser_strobe) [*4] |-> $stable(readback_out))
    else $error("readback moved");
  cover property (code_load);
  cover property ($rose(ser_strobe));
  cover property ($changed(readback_out));
endmodule

// file: tb/host_model.sv
// Host side of the three-wire serial link
module host_model (
  input  wire logic clk, readback_out,
  output logic      ser_clk, ser_data, ser_strobe);
  timeunit 1ns; timeprecision 1ns;
  initial begin ser_clk = 0; ser_data = 0; ser_strobe = 1; end
  // Each level stands 5 clocks, above the 4-clock minimum
  task automatic hold(); repeat (5) @(posedge clk); #1; endtask
  // Word bit 0 first, then 32 zero clocks shift the readback out
  task automatic xfer(input logic [31:0] w, output logic [31:0] rb);
    ser_strobe = 0;
    for (int i = 0; i < 64; i++) begin
      if (i == 32) begin ser_strobe = 1; hold(); ser_strobe = 0; end
      ser_data = i < 32 ? w[i] : 1'b0;
      hold();
      if (i > 31) rb[i-32] = readback_out;
      ser_clk = 1; hold(); ser_clk = 0;
    end
    hold(); ser_strobe = 1; ser_data = 1; hold(); // Zero word hits no register
  endtask
endmodule

// file: tb/demod_trim_and_readback_regs_bench.sv
// Self-checking bench for the trim and readback register block
module demod_trim_and_readback_regs_bench;
  timeunit 1ns; timeprecision 1ns;
  import trim_readback_pkg::*;
  logic clk = 0, rst = 1, code_load = 0, sc, sd, ss, rbo;
  logic [7:0] ic = 0, qc = 0, qo, io, ei = 8'h80, eq = 8'h80;
  logic [11:0] tr, et = 12'h555;
  logic [31:0] lf = 32'h9349, w, rb;
  int fail_count = 0, samples_checked = 0;
  always #50 clk = ~clk;
  host_model i_host (.clk, .readback_out(rbo), .ser_clk(sc), .ser_data(sd), .ser_strobe(ss));
  trim_readback_regs i_dut (.clk, .rst, .ser_clk(sc), .ser_data(sd), .ser_strobe(ss),
    .inphase_code_in(ic), .quad_code_in(qc), .code_load, .mixer_transconductance_bias(tr[1:0]),
    .mixer_switch_common_mode(tr[3:2]), .local_osc_buffer_bias(tr[5:4]),
    .mixer_out_buffer_bias(tr[7:6]), .filter_bias(tr[9:8]), .filter_out_buffer_bias(tr[11:10]),
    .quadrature_offset_code(qo), .inphase_offset_code(io), .readback_out(rbo));
  function automatic logic [31:0] nx(logic [31:0] v); return {v[30:0], ^(v & 32'h8020_0003)};
  endfunction
  function automatic logic [31:0] exp_rb(logic [4:0] a); return {ei, eq, 9'h0, VERSION_CODE, a};
  endfunction
  task automatic check(input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp) begin fail_count++; $display("MISMATCH %0t %h %h", $time, got, exp); end
  endtask
  task automatic final_report();
    $display("compares %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin repeat (60000) @(posedge clk); fail_count++; final_report(); end
  // Random trims and codes after pass 0, near-miss addresses on passes 2, 4 and 6
  initial begin
    repeat (16) @(posedge clk);
    #1 rst = 0;
    check(tr, et);
    check({io, qo}, {ei, eq});
    for (int k = 0; k < 8; k++) begin
      lf = nx(lf);
      if (k > 0) begin ic = lf[15:8]; qc = lf[23:16]; ei = ic; eq = qc; code_load = 1; end
      @(posedge clk); #1 code_load = 0;
      check({io, qo}, {ei, eq});
      w = {lf[31:5], k[0] ? BIAS_TRIM_ADDR : BIAS_TRIM_ADDR ^ 5'(1 << (k % 5))};
      if (k == 0) w = {lf[31:17], 12'h64E, BIAS_TRIM_ADDR};
      if (w[4:0] == BIAS_TRIM_ADDR) et = w[16:5];
      i_host.xfer(w, rb);
      check(tr, et);
      i_host.xfer({lf[4:0], 22'h0, READBACK_CMD}, rb);
      check(rb, exp_rb(lf[4:0]));
      $display("test %0d done", k);
    end
    et = 12'h555;
    i_host.xfer({lf[31:17], et, BIAS_TRIM_ADDR}, rb);
    check(tr, et);
    $display("test default trims done");
    final_report();
  end
endmodule
bind trim_readback_regs trim_readback_checker i_chk (.*);
